/* File: port_event_end.sv */
// Port pin and event routing end: edge sensing, pin override and event fan-out.
// Assumes pin inputs are already synchronous to clk.
module port_event_end (
	input wire logic clk,
	input wire logic rstn,
	timer_port_if.port link,
	input wire logic [3:0] pin_i,
	output logic [3:0] pin_o,
	output logic [3:0] pin_oe,
	input wire logic [3:0] pin_out_reg,
	input wire logic [3:0] pin_dir,
	input wire logic [3:0] pin_invert_enable,
	input wire logic [3:0] sense_both_edges,
	output logic [5:0] routed_event
);
	logic [3:0] prev_q;
	logic [3:0] pulse_q;
	logic [3:0] rise_q;
	logic [3:0] pin_o_q;
	logic [5:0] routed_q;
	logic [3:0] rise;
	logic [3:0] fall;

	assign rise = pin_i & ~prev_q;
	assign fall = ~pin_i & prev_q;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			prev_q <= 4'h0;
			pulse_q <= 4'h0;
			rise_q <= 4'h0;
		end else begin
			prev_q <= pin_i;
			pulse_q <= rise | (fall & sense_both_edges); // [R5]
			rise_q <= rise;
		end
	end

	// Inversion applies to whichever source drives the pin.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			pin_o_q <= 4'h0;
		end else begin
			pin_o_q <= ((link.override & link.waveform_output) | (~link.override & pin_out_reg))
				^ pin_invert_enable; // [R11] [R12]
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			routed_q <= 6'h00;
		end else begin
			routed_q <= {link.err_event, link.cc_event, link.ovf_event}; // [R18]
		end
	end

	assign link.ev_pulse = pulse_q;
	assign link.ev_rise = rise_q;
	assign pin_o = pin_o_q;
	assign pin_oe = pin_dir; // [R10]
	assign routed_event = routed_q;
endmodule // port_event_end

/* File: tb_top.sv */
// Testbench joining the timer channel block and the port end through their link.
// Assumes the register map and bus timing of the shared timer package.
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {
		logic [7:0] mode;
		logic [15:0] cc;
		logic inv;
		logic [7:0] hi;
		logic [7:0] tg;
	} row_type;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic irq_overflow;
	logic irq_error;
	logic [3:0] irq_channel;
	logic [3:0] pin_i = 4'h0;
	logic [3:0] pin_o;
	logic [3:0] pin_oe;
	logic [3:0] pin_out_reg = 4'ha;
	logic [3:0] pin_dir = 4'h0;
	logic [3:0] pin_invert_enable = 4'h0;
	logic [3:0] sense_both_edges = 4'h0;
	logic [5:0] routed_event;
	logic [31:0] scratch;
	int n_mismatch = 0;
	int comparisons = 0;
	// Each row is twelve cycles of pin drive with period value 3.
	row_type rows [9] = '{
		'{8'h13, 16'h0000, 1'b0, 8'h09, 8'h06},
		'{8'h13, 16'h0001, 1'b0, 8'h06, 8'h06},
		'{8'h13, 16'h0003, 1'b0, 8'h00, 8'h00},
		'{8'h13, 16'h0000, 1'b1, 8'h03, 8'h06},
		'{8'h11, 16'h0000, 1'b0, 8'h06, 8'h0c},
		'{8'h11, 16'h0001, 1'b0, 8'h06, 8'h06},
		'{8'h15, 16'h0002, 1'b0, 8'h08, 8'h04},
		'{8'h16, 16'h0002, 1'b0, 8'h08, 8'h04},
		'{8'h17, 16'h0002, 1'b0, 8'h08, 8'h04}
	};

	timer_port_if link_if ();

	always #50 clk = ~clk;

	timer_capture_compare_waveform u_timer_capture_compare_waveform (
		.clk(clk),
		.rstn(rstn),
		.link(link_if.device),
		.avs_address(avs_address),
		.avs_read(avs_read),
		.avs_write(avs_write),
		.avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.irq_overflow(irq_overflow),
		.irq_error(irq_error),
		.irq_channel(irq_channel)
	);
	port_event_end u_port_event_end (
		.clk(clk),
		.rstn(rstn),
		.link(link_if.port),
		.pin_i(pin_i),
		.pin_o(pin_o),
		.pin_oe(pin_oe),
		.pin_out_reg(pin_out_reg),
		.pin_dir(pin_dir),
		.pin_invert_enable(pin_invert_enable),
		.sense_both_edges(sense_both_edges),
		.routed_event(routed_event)
	);
	timer_link_sva u_timer_link_sva (
		.clk(clk),
		.rstn(rstn),
		.ev_pulse(link_if.ev_pulse),
		.waveform_output(link_if.waveform_output),
		.override(link_if.override),
		.ovf_event(link_if.ovf_event),
		.cc_event(link_if.cc_event),
		.err_event(link_if.err_event),
		.irq_overflow(irq_overflow),
		.irq_error(irq_error),
		.irq_channel(irq_channel),
		.avs_write(avs_write),
		.avs_waitrequest(avs_waitrequest),
		.pin_o(pin_o),
		.pin_out_reg(pin_out_reg),
		.pin_invert_enable(pin_invert_enable)
	);

	task give_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Waitrequest and read data are read right after the rising edge, before any flop updates.
	task bus(input logic wr_en, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr_en;
		avs_read <= !wr_en;
		n = 0;
		do begin
			@(posedge clk);
			n++;
			if (n > 20) begin
				n_mismatch++;
				give_verdict();
			end
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task rdc(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		check(q & mask, e);
	endtask

	task pulse(input int w, input int g);
		pin_i[0] <= 1'b1;
		repeat (w) @(posedge clk);
		pin_i[0] <= 1'b0;
		repeat (g) @(posedge clk);
	endtask

	task run_row(input row_type r);
		logic [7:0] hi;
		logic [7:0] tg;
		logic [5:0] ev_or;
		logic prev;
		wr(timer_pkg::off_mode, {24'h0, r.mode});
		wr(timer_pkg::off_compare, {16'h0, r.cc});
		pin_invert_enable <= {3'b000, r.inv};
		wr(timer_pkg::off_command, 32'h2);
		repeat (8) @(posedge clk);
		hi = 8'h00;
		tg = 8'h00;
		ev_or = 6'h00;
		prev = 1'b0;
		for (int k = 0; k < 13; k++) begin
			@(negedge clk);
			if (k > 0 && pin_o[0] !== prev) tg++;
			if (k < 12 && pin_o[0] === 1'b1) hi++;
			ev_or = ev_or | routed_event;
			prev = pin_o[0];
		end
		check({26'h0, ev_or}, 32'h1f);
		check({24'h0, hi}, {24'h0, r.hi});
		check({24'h0, tg}, {24'h0, r.tg});
		check({31'h0, link_if.override[0]}, 32'h1);
	endtask

	initial begin
		repeat (30000) @(posedge clk);
		n_mismatch++;
		give_verdict();
	end

	initial begin
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		wr(timer_pkg::off_irq_enable, 32'h3f);
		wr(timer_pkg::off_mode, 32'h10);
		wr(timer_pkg::off_event, 32'ha0);
		wr(timer_pkg::off_clock, 32'h1);
		repeat (3) pulse(3, 7);
		repeat (4) @(posedge clk);
		check({31'h0, irq_error}, 32'h1);
		rdc(timer_pkg::off_status, 32'h112, 32'h112);
		bus(1'b0, timer_pkg::off_compare, 32'h0, scratch);
		rdc(timer_pkg::off_compare, 32'hffff, 32'h9);
		rdc(timer_pkg::off_status, 32'h110, 32'h0);
		sense_both_edges <= 4'h1;
		wr(timer_pkg::off_event, 32'hd0);
		wr(timer_pkg::off_status, 32'hf3);
		pulse(6, 6);
		repeat (4) @(posedge clk);
		rdc(timer_pkg::off_compare, 32'hffff, 32'h5);
		wr(timer_pkg::off_event, 32'h0);
		wr(timer_pkg::off_period, 32'h3);
		pin_dir <= 4'h1;
		foreach (rows[i]) run_row(rows[i]);
		check({28'h0, irq_channel & 4'h1}, 32'h1);
		check({31'h0, irq_overflow}, 32'h1);
		check({28'h0, pin_oe}, 32'h1);
		// A stopped timer never reaches an update point, so only the command can load the compare value from the buffer.
		wr(timer_pkg::off_clock, 32'h0);
		wr(timer_pkg::off_compare, 32'h1);
		wr(timer_pkg::off_compare_buf, 32'h2);
		rdc(timer_pkg::off_compare, 32'hffff, 32'h1);
		wr(timer_pkg::off_command, 32'h1);
		rdc(timer_pkg::off_compare, 32'hffff, 32'h2);
		wr(timer_pkg::off_command, 32'h100);
		wr(timer_pkg::off_compare_buf, 32'h3);
		wr(timer_pkg::off_command, 32'h101);
		rdc(timer_pkg::off_compare, 32'hffff, 32'h2);
		wr(timer_pkg::off_command, 32'h0);
		wr(timer_pkg::off_counter, 32'h5);
		wr(timer_pkg::off_direct, 32'hf);
		@(posedge clk);
		check({28'h0, link_if.waveform_output}, 32'hf);
		wr(timer_pkg::off_command, 32'h2);
		rdc(timer_pkg::off_counter, 32'hffff, 32'h0);
		rdc(timer_pkg::off_status, 32'h1000, 32'h0);
		check({28'h0, link_if.waveform_output}, 32'h0);
		wr(timer_pkg::off_clock, 32'h1);
		wr(timer_pkg::off_command, 32'h4);
		rdc(timer_pkg::off_period, 32'hffff, 32'h3);
		wr(timer_pkg::off_clock, 32'h0);
		wr(timer_pkg::off_command, 32'h4);
		rdc(timer_pkg::off_period, 32'hffff, 32'hffff);
		rdc(timer_pkg::off_mode, 32'hff, 32'h0);
		check({28'h0, link_if.override}, 32'h0);
		rstn <= 1'b0;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		rdc(timer_pkg::off_period, 32'hffffffff, 32'hffff);
		rdc(timer_pkg::off_counter, 32'hffffffff, 32'h0);
		rdc(8'hfc, 32'hffffffff, 32'h0);
		check({28'h0, pin_o}, {28'h0, pin_out_reg});
		give_verdict();
	end
endmodule // tb_top

/* File: timer_capture_compare_waveform.sv */
// Capture and compare channels of a 16-bit timer with waveform generation.
// Assumes events arrive as one-cycle pulses with edge polarity on the link.
// Behaviour
// R1: frequency capture stores counter then restarts it
// R2: stored value counts ticks since last restart
// R3: software enables one channel in frequency capture
// R4: pulse width: rise restarts, fall captures
// R5: pin sensing must flag both edges
// R6: upper cascaded timer needs one-cycle event delay
// R7: full buffer discards capture, sets error flag
// R8: compare equality sets flag, event, interrupt
// R9: buffered compare loads only at update point
// R10: software picks mode, no action, output pin
// R11: enabled waveform channel overrides pin output
// R12: pin invert inverts driven waveform
// R13: frequency mode toggles at channel A period
// R14: single slope: set on match, clear at top
// R15: period value sets resolution, minimum three
// R16: dual slope: up clears, down sets, bottom sets
// R17: overflow, per-channel and error interrupts
// R18: every interrupt condition also gives an event
// R19: software update acts unless update locked
// R20: restart clears counter, direction and outputs
// R21: reset command only while timer is off
// R22: capture buffer and value form two-entry queue
// R23: event delay holds events one clock
// R24: capture restart zeroes counter same clock
module timer_capture_compare_waveform (
	input wire logic clk,
	input wire logic rstn,
	timer_port_if.device link,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic irq_overflow,
	output logic irq_error,
	output logic [3:0] irq_channel
);
	logic done_q, event_delay_bit_q, lock_q, dir_q, period_buffer_valid_q, ovf_flag_q, err_flag_q;
	logic [31:0] rdata_q, rmux;
	logic [3:0] clksel_q, channel_enable_q, ev_dly_q, rise_dly_q, buffer_valid_flag_q, cc_flag_q;
	logic [3:0] waveform_output_q, ev_sel, rise_sel, ch_ev, ch_rise, cap_trig, match, cc_read;
	logic [3:0] wr_cc, wr_buf, room, cc_set, overflow;
	logic [2:0] wgmode_q, evact_q;
	logic [1:0] evsel_q;
	logic [5:0] inten_q, evt_q;
	logic [9:0] pre_q;
	logic [15:0] counter_value_q, period_value_q, period_buf_q, top;
	logic [15:0] channel_compare_value_q [4];
	logic [15:0] cc_buf_q [4];
	logic wr, rd, clear, running, tick, cmd_hit, cmd_update, restart_all, restart_cnt;
	logic capture_mode, dual, at_top, at_bot, update, ovf_ev;

	function automatic logic [7:0] cc_addr(input logic [7:0] base, input int i);
		return base + 8'(i) * timer_pkg::channel_stride;
	endfunction

	// Every access takes one wait cycle; the write lands on the edge where wait is low.
	assign avs_waitrequest = (avs_read | avs_write) & ~done_q;
	assign wr = avs_write & done_q;
	assign rd = avs_read & done_q;
	assign avs_readdata = rdata_q;

	assign cmd_hit = wr && avs_address == timer_pkg::off_command;
	assign running = clksel_q != 4'h0;
	assign clear = !rstn || (cmd_hit && avs_writedata[timer_pkg::cmd_reset_bit] && !running); // [R21]
	// Event channel clock sources are not counted here; such a selection only holds the counter.
	assign tick = running && !clksel_q[3]
		&& (pre_q & timer_pkg::div_mask[clksel_q[2:0]]) == timer_pkg::div_mask[clksel_q[2:0]];
	assign cmd_update = cmd_hit && avs_writedata[timer_pkg::cmd_update_bit] && !lock_q; // [R19]

	assign ev_sel = event_delay_bit_q ? ev_dly_q : link.ev_pulse; // [R23] [R6]
	assign rise_sel = event_delay_bit_q ? rise_dly_q : link.ev_rise;
	assign capture_mode = evact_q == timer_pkg::act_capture || evact_q == timer_pkg::act_freq_capture
		|| evact_q == timer_pkg::act_pulse_width;
	assign dual = wgmode_q[2];
	assign top = (wgmode_q == timer_pkg::frequency_waveform_mode) ? channel_compare_value_q[0]
		: period_value_q; // [R13]
	assign at_top = tick && counter_value_q == top;
	assign at_bot = tick && counter_value_q == 16'h0000;
	assign update = ((wgmode_q == timer_pkg::normal_mode
		|| wgmode_q == timer_pkg::frequency_waveform_mode) ? at_top : at_bot) || cmd_update; // [R9]

	always_comb begin
		unique case (wgmode_q)
			timer_pkg::normal_mode, timer_pkg::frequency_waveform_mode, timer_pkg::dual_top_mode:
				ovf_ev = at_top;
			timer_pkg::single_slope_mode, timer_pkg::dual_bottom_mode: ovf_ev = at_bot;
			timer_pkg::dual_both_mode: ovf_ev = at_top || at_bot;
			default: ovf_ev = 1'b0;
		endcase
	end

	always_comb begin
		logic [1:0] idx;
		idx = 2'b00;
		for (int i = 0; i < 4; i++) begin
			idx = 2'(i) + evsel_q;
			ch_ev[i] = ev_sel[idx];
			ch_rise[i] = rise_sel[idx];
			match[i] = counter_value_q == channel_compare_value_q[i];
			cc_read[i] = rd && avs_address == cc_addr(timer_pkg::off_compare, i);
			wr_cc[i] = wr && avs_address == cc_addr(timer_pkg::off_compare, i);
			wr_buf[i] = wr && avs_address == cc_addr(timer_pkg::off_compare_buf, i);
			cap_trig[i] = channel_enable_q[i] && ch_ev[i] && (evact_q == timer_pkg::act_capture
				|| (evact_q == timer_pkg::act_freq_capture && ch_rise[i]) // [R1]
				|| (evact_q == timer_pkg::act_pulse_width && !ch_rise[i])); // [R4]
			room[i] = !cc_flag_q[i] || cc_read[i];
			overflow[i] = capture_mode && cap_trig[i] && buffer_valid_flag_q[i] && !room[i]; // [R7]
			cc_set[i] = capture_mode ? (room[i] && (buffer_valid_flag_q[i] || cap_trig[i]))
				: (tick && match[i]); // [R8]
		end
	end

	// Frequency and pulse-width capture restart on the rising edge of any enabled source, hence one channel only.
	assign restart_all = (cmd_hit && avs_writedata[timer_pkg::cmd_restart_bit])
		|| (evact_q == timer_pkg::act_restart && ch_ev[0]);
	assign restart_cnt = restart_all || ((evact_q == timer_pkg::act_freq_capture
		|| evact_q == timer_pkg::act_pulse_width) && |(channel_enable_q & ch_ev & ch_rise)); // [R3]

	always_ff @(posedge clk) begin
		if (!rstn) begin
			done_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end else begin
			done_q <= (avs_read | avs_write) & ~done_q;
			rdata_q <= rmux;
		end
	end

	always_ff @(posedge clk) begin
		if (clear) begin
			clksel_q <= 4'h0;
			channel_enable_q <= 4'h0;
			wgmode_q <= 3'h0;
			evact_q <= 3'h0;
			event_delay_bit_q <= 1'b0;
			evsel_q <= 2'h0;
			lock_q <= 1'b0;
			inten_q <= 6'h00;
		end else if (wr) begin
			if (avs_address == timer_pkg::off_clock) clksel_q <= avs_writedata[3:0];
			if (avs_address == timer_pkg::off_mode) begin
				channel_enable_q <= avs_writedata[timer_pkg::enable_lsb +: 4];
				wgmode_q <= avs_writedata[2:0];
			end
			if (avs_address == timer_pkg::off_event) begin
				evact_q <= avs_writedata[timer_pkg::evact_lsb +: 3];
				event_delay_bit_q <= avs_writedata[timer_pkg::delay_bit];
				evsel_q <= avs_writedata[1:0];
			end
			if (cmd_hit) lock_q <= avs_writedata[timer_pkg::cmd_lock_bit];
			if (avs_address == timer_pkg::off_irq_enable) inten_q <= avs_writedata[5:0];
		end
	end

	always_ff @(posedge clk) begin
		if (clear) begin
			pre_q <= 10'h000;
			ev_dly_q <= 4'h0;
			rise_dly_q <= 4'h0;
		end else begin
			pre_q <= running ? pre_q + 10'h001 : 10'h000;
			ev_dly_q <= link.ev_pulse;
			rise_dly_q <= link.ev_rise;
		end
	end

	// A period of zero in dual slope would turn the count at zero and wrap it.
	always_ff @(posedge clk) begin
		if (clear) begin
			counter_value_q <= timer_pkg::counter_reset;
			dir_q <= 1'b0;
		end else if (wr && avs_address == timer_pkg::off_counter) begin
			counter_value_q <= avs_writedata[15:0];
		end else if (restart_cnt) begin
			counter_value_q <= timer_pkg::counter_reset; // [R20] [R24] [R2]
			dir_q <= 1'b0;
		end else if (tick) begin
			if (!dual) begin
				counter_value_q <= (counter_value_q == top) ? 16'h0000 : counter_value_q + 16'h0001; // [R14]
			end else if (!dir_q) begin
				dir_q <= counter_value_q == top; // [R15] [R16]
				counter_value_q <= (counter_value_q == top) ? counter_value_q - 16'h0001
					: counter_value_q + 16'h0001;
			end else begin
				dir_q <= counter_value_q != 16'h0000;
				counter_value_q <= (counter_value_q == 16'h0000) ? 16'h0001
					: counter_value_q - 16'h0001;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (clear) begin
			period_value_q <= timer_pkg::period_reset;
			period_buf_q <= timer_pkg::period_reset;
			period_buffer_valid_q <= 1'b0;
		end else if (wr && avs_address == timer_pkg::off_period) begin
			period_value_q <= avs_writedata[15:0];
		end else if (wr && avs_address == timer_pkg::off_period_buf) begin
			period_buf_q <= avs_writedata[15:0];
			period_buffer_valid_q <= 1'b1;
		end else if (update && period_buffer_valid_q) begin
			period_value_q <= period_buf_q; // [R9]
			period_buffer_valid_q <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		for (int i = 0; i < 4; i++) begin
			if (clear) begin
				channel_compare_value_q[i] <= timer_pkg::compare_reset;
				cc_buf_q[i] <= timer_pkg::compare_reset;
				buffer_valid_flag_q[i] <= 1'b0;
			end else if (wr_cc[i]) begin
				channel_compare_value_q[i] <= avs_writedata[15:0];
			end else if (wr_buf[i]) begin
				cc_buf_q[i] <= avs_writedata[15:0];
				buffer_valid_flag_q[i] <= 1'b1;
			end else if (capture_mode) begin
				if (buffer_valid_flag_q[i] && room[i]) begin
					channel_compare_value_q[i] <= cc_buf_q[i]; // [R22]
					if (cap_trig[i]) cc_buf_q[i] <= counter_value_q;
					else buffer_valid_flag_q[i] <= 1'b0;
				end else if (cap_trig[i] && room[i]) begin
					channel_compare_value_q[i] <= counter_value_q; // [R2] [R22]
				end else if (cap_trig[i] && !buffer_valid_flag_q[i]) begin
					cc_buf_q[i] <= counter_value_q;
					buffer_valid_flag_q[i] <= 1'b1;
				end
			end else if (update && buffer_valid_flag_q[i]) begin
				channel_compare_value_q[i] <= cc_buf_q[i]; // [R9]
				buffer_valid_flag_q[i] <= 1'b0;
			end
		end
	end

	// Flags: a hardware set in the same cycle as a clear wins.
	always_ff @(posedge clk) begin
		if (clear) begin
			cc_flag_q <= 4'h0;
			ovf_flag_q <= 1'b0;
			err_flag_q <= 1'b0;
		end else begin
			cc_flag_q <= (cc_flag_q & ~((wr && avs_address == timer_pkg::off_status)
				? avs_writedata[timer_pkg::st_flag_lsb +: 4] : (capture_mode ? cc_read : 4'h0)))
				| cc_set; // [R8]
			ovf_flag_q <= (ovf_flag_q & ~(wr && avs_address == timer_pkg::off_status
				&& avs_writedata[timer_pkg::st_overflow_bit])) | ovf_ev;
			err_flag_q <= (err_flag_q & ~(wr && avs_address == timer_pkg::off_status
				&& avs_writedata[timer_pkg::st_error_bit])) | |overflow; // [R7]
		end
	end

	always_ff @(posedge clk) begin
		if (clear || restart_all) begin
			waveform_output_q <= 4'h0; // [R20]
		end else if (!running && wr && avs_address == timer_pkg::off_direct) begin
			waveform_output_q <= avs_writedata[3:0];
		end else if (tick) begin
			for (int i = 0; i < 4; i++) begin
				if (wgmode_q == timer_pkg::frequency_waveform_mode) begin
					if (i == 0 && at_top) waveform_output_q[i] <= ~waveform_output_q[i]; // [R13]
				end else if (wgmode_q == timer_pkg::single_slope_mode) begin
					if (at_top) waveform_output_q[i] <= 1'b0; // [R14]
					else if (match[i]) waveform_output_q[i] <= 1'b1;
				end else if (dual) begin
					if (at_bot) waveform_output_q[i] <= 1'b1; // [R16]
					else if (match[i]) waveform_output_q[i] <= dir_q;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) evt_q <= 6'h00;
		else evt_q <= {|overflow, cc_set, ovf_ev}; // [R18]
	end

	always_comb begin
		rmux = 32'h0000_0000;
		unique case (avs_address)
			timer_pkg::off_clock: rmux[3:0] = clksel_q;
			timer_pkg::off_mode: rmux[7:0] = {channel_enable_q, 1'b0, wgmode_q};
			timer_pkg::off_direct: rmux[3:0] = waveform_output_q;
			timer_pkg::off_event: rmux[7:0] = {evact_q, event_delay_bit_q, 2'b00, evsel_q};
			timer_pkg::off_command: rmux[timer_pkg::cmd_lock_bit] = lock_q;
			timer_pkg::off_status: rmux[13:0] = {period_buffer_valid_q, dir_q, buffer_valid_flag_q,
				cc_flag_q, 2'b00, err_flag_q, ovf_flag_q};
			timer_pkg::off_irq_enable: rmux[5:0] = inten_q;
			timer_pkg::off_counter: rmux[15:0] = counter_value_q;
			timer_pkg::off_period: rmux[15:0] = period_value_q;
			timer_pkg::off_period_buf: rmux[15:0] = period_buf_q;
			default: begin
				for (int i = 0; i < 4; i++) begin
					if (avs_address == cc_addr(timer_pkg::off_compare, i))
						rmux[15:0] = channel_compare_value_q[i];
					if (avs_address == cc_addr(timer_pkg::off_compare_buf, i))
						rmux[15:0] = cc_buf_q[i];
				end
			end
		endcase
	end

	assign link.waveform_output = waveform_output_q;
	assign link.override = channel_enable_q & {4{wgmode_q != timer_pkg::normal_mode}}; // [R11]
	assign link.ovf_event = evt_q[0];
	assign link.cc_event = evt_q[4:1];
	assign link.err_event = evt_q[5];
	assign irq_overflow = ovf_flag_q & inten_q[0]; // [R17]
	assign irq_error = err_flag_q & inten_q[1];
	assign irq_channel = cc_flag_q & inten_q[5:2];
endmodule // timer_capture_compare_waveform

/* File: timer_link_sva.sv */
// Checker for the link between the timer channel block and its port end.
// Assumes one clock and a synchronous active-low reset shared by both ends.
module timer_link_sva (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [3:0] ev_pulse,
	input wire logic [3:0] waveform_output,
	input wire logic [3:0] override,
	input wire logic ovf_event,
	input wire logic [3:0] cc_event,
	input wire logic err_event,
	input wire logic irq_overflow,
	input wire logic irq_error,
	input wire logic [3:0] irq_channel,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	input wire logic [3:0] pin_o,
	input wire logic [3:0] pin_out_reg,
	input wire logic [3:0] pin_invert_enable
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] drive_sel;

	// The pin end registers its drive, so the selection is kept one cycle for comparison.
	assign drive_sel = ((override & waveform_output) | (~override & pin_out_reg)) ^ pin_invert_enable;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	sequence s_err_soon;
		##[0:1] err_event;
	endsequence
	property p_reset_quiet;
		$rose(rstn) |-> (waveform_output | override | cc_event) == 4'h0 && !ovf_event && !err_event;
	endproperty
	property p_err_single;
		err_event |=> !err_event;
	endproperty
	property p_err_cause;
		err_event |-> ($past(ev_pulse) | $past(ev_pulse, 2) | $past(ev_pulse, 3)) != 4'h0;
	endproperty
	property p_irq_err;
		$rose(irq_error) |-> s_err_soon;
	endproperty
	property p_irq_ovf;
		$rose(irq_overflow) |-> ##[0:1] ovf_event;
	endproperty
	property p_irq_cc;
		(irq_channel & ~$past(irq_channel)) != 4'h0 |-> ##[0:2] (cc_event != 4'h0);
	endproperty
	property p_override_write;
		$changed(override) |-> $past(avs_write) && !$past(avs_waitrequest);
	endproperty
	property p_pin_drive;
		$past(rstn) |-> pin_o == $past(drive_sel);
	endproperty

	a_reset_quiet: assert property (p_reset_quiet)
		else $error("link outputs not idle after reset");
	a_err_single: assert property (p_err_single)
		else $error("error event longer than one cycle");
	a_err_cause: assert property (p_err_cause)
		else $error("error event without a capture event");
	a_irq_err: assert property (p_irq_err)
		else $error("error interrupt without error event");
	a_irq_ovf: assert property (p_irq_ovf)
		else $error("overflow interrupt without overflow event");
	a_irq_cc: assert property (p_irq_cc)
		else $error("channel interrupt without channel event");
	a_override_write: assert property (p_override_write)
		else $error("override changed without a register write");
	a_pin_drive: assert property (p_pin_drive)
		else $error("pin drive differs from selected waveform");

	c_err: cover property (err_event);
	c_ovf: cover property (ovf_event);
	c_cc: cover property (cc_event[0]);
endmodule // timer_link_sva

/* File: timer_pkg.sv */
// Shared constants and types for the timer channel block and its port end.
// Assumes a 32-bit Avalon-MM register bus with byte addresses on eight bits.
package timer_pkg;

	typedef enum logic [2:0] {
		normal_mode = 3'b000,
		frequency_waveform_mode = 3'b001,
		single_slope_mode = 3'b011,
		dual_top_mode = 3'b101,
		dual_both_mode = 3'b110,
		dual_bottom_mode = 3'b111
	} wgmode_type;

	typedef enum logic [2:0] {
		act_off = 3'b000,
		act_capture = 3'b001,
		act_updown = 3'b010,
		act_quadrature = 3'b011,
		act_restart = 3'b100,
		act_freq_capture = 3'b101,
		act_pulse_width = 3'b110
	} evact_type;

	localparam logic [7:0] off_clock = 8'h00;
	localparam logic [7:0] off_mode = 8'h04;
	localparam logic [7:0] off_direct = 8'h08;
	localparam logic [7:0] off_event = 8'h0c;
	localparam logic [7:0] off_command = 8'h10;
	localparam logic [7:0] off_status = 8'h14;
	localparam logic [7:0] off_irq_enable = 8'h18;
	localparam logic [7:0] off_counter = 8'h1c;
	localparam logic [7:0] off_period = 8'h20;
	localparam logic [7:0] off_period_buf = 8'h24;
	localparam logic [7:0] off_compare = 8'h28;
	localparam logic [7:0] off_compare_buf = 8'h38;
	localparam logic [7:0] channel_stride = 8'h04;

	localparam int enable_lsb = 4;
	localparam int delay_bit = 4;
	localparam int evact_lsb = 5;
	localparam int cmd_update_bit = 0;
	localparam int cmd_restart_bit = 1;
	localparam int cmd_reset_bit = 2;
	localparam int cmd_lock_bit = 8;
	localparam int st_overflow_bit = 0;
	localparam int st_error_bit = 1;
	localparam int st_flag_lsb = 4;

	localparam logic [15:0] counter_reset = 16'h0000;
	localparam logic [15:0] period_reset = 16'hffff;
	localparam logic [15:0] compare_reset = 16'h0000;

	// Prescaler masks per clock select code; a tick comes when all mask bits are set.
	localparam logic [9:0] div_mask [8] = '{10'h000, 10'h000, 10'h001, 10'h003,
		10'h007, 10'h03f, 10'h0ff, 10'h3ff};

endpackage

/* File: timer_port_if.sv */
// Link between the timer channel block and the port pin and event routing end.
// Both ends run on the same clock; every signal here is sampled on its edge.
interface timer_port_if;
	logic [3:0] ev_pulse;
	logic [3:0] ev_rise;
	logic [3:0] waveform_output;
	logic [3:0] override;
	logic ovf_event;
	logic [3:0] cc_event;
	logic err_event;

	modport device (input ev_pulse, input ev_rise, output waveform_output, output override,
		output ovf_event, output cc_event, output err_event);
	modport port (output ev_pulse, output ev_rise, input waveform_output, input override,
		input ovf_event, input cc_event, input err_event);
endinterface
